// >>> design/twc_pkg.sv
// constants for the 8-bit timer waveform control block
package twc_pkg;
  // register byte offsets
  localparam logic [7:0] TWC_OFS_CTRL_A = 8'h00;
  localparam logic [7:0] TWC_OFS_CTRL_B = 8'h04;
  localparam logic [7:0] TWC_OFS_COUNT  = 8'h08;
  localparam logic [7:0] TWC_OFS_CMP_A  = 8'h0c;
  localparam logic [7:0] TWC_OFS_CMP_B  = 8'h10;
  localparam logic [7:0] TWC_OFS_STAT   = 8'h14;
  localparam logic [7:0] TWC_OFS_MASK   = 8'h18;
  localparam logic [7:0] TWC_OFS_DIR    = 8'h1c;
  // control a fields
  localparam int TWC_A_FLD_HI  = 7;
  localparam int TWC_A_FLD_LO  = 6;
  localparam int TWC_B_FLD_HI  = 5;
  localparam int TWC_B_FLD_LO  = 4;
  localparam logic [7:0] TWC_CTRL_A_WMASK = 8'hf3;
  // control b fields
  localparam int TWC_B_MODE_HI = 3;
  localparam int TWC_B_RUN     = 0;
  localparam logic [7:0] TWC_CTRL_B_WMASK = 8'h09;
  // status and mask bit positions
  localparam int TWC_ST_OVF = 0;
  localparam int TWC_ST_MA  = 1;
  localparam int TWC_ST_MB  = 2;
  localparam logic [7:0] TWC_ST_WMASK = 8'h07;
  localparam logic [7:0] TWC_DIR_WMASK = 8'h03;
  localparam int TWC_DIR_A = 0;
  localparam int TWC_DIR_B = 1;
  // reset values
  localparam logic [7:0] TWC_RST_BYTE = 8'h00;
  localparam logic [31:0] TWC_RST_WORD = 32'h0000_0000;
  // counter landmarks
  localparam logic [7:0] TWC_MAX    = 8'hff;
  localparam logic [7:0] TWC_BOTTOM = 8'h00;
  localparam logic [7:0] TWC_ONE    = 8'h01;
  // waveform modes
  localparam logic [2:0] TWC_M_NORMAL = 3'h0;
  localparam logic [2:0] TWC_M_PC_MAX = 3'h1;
  localparam logic [2:0] TWC_M_CTC    = 3'h2;
  localparam logic [2:0] TWC_M_FP_MAX = 3'h3;
  localparam logic [2:0] TWC_M_PC_OCA = 3'h5;
  localparam logic [2:0] TWC_M_FP_OCA = 3'h7;
  // output action field codes
  localparam logic [1:0] TWC_ACT_OFF = 2'h0;
  localparam logic [1:0] TWC_ACT_TGL = 2'h1;
  localparam logic [1:0] TWC_ACT_CLR = 2'h2;
  localparam logic [1:0] TWC_ACT_SET = 2'h3;
  // axi responses
  localparam logic [1:0] TWC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TWC_RESP_SLVERR = 2'h2;
endpackage

// >>> design/twc_top.sv
// 8-bit timer/counter with two waveform outputs behind an axi4-lite slave
// Behaviour
// - timer tick is clock enable for counter
// - output a overrides pin when field nonzero
// - non-pwm a: off, toggle, clear, set
// - fast pwm a: toggle needs high bit; bottom action
// - fast pwm compare equals top: bottom only
// - phase pwm compare equals top: act at top
// - phase pwm a: up/down match clear/set
// - output b overrides pin when field nonzero
// - non-pwm b: off, toggle, clear, set
// - fast pwm b: 01 reserved, else bottom action
// - phase pwm b: 01 reserved, up/down action
// - control a bits 3:2 read zero
// - three-bit mode from two registers
// - mode table: sequence, top, update point
// - overflow flag point follows mode
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module twc_top
  import twc_pkg::*;
(
  // clock, reset, freeze
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        mclk_en,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // compare output pins
  output var  logic        compare_output_a,
  output var  logic        compare_output_a_oe,
  output var  logic        compare_output_b,
  output var  logic        compare_output_b_oe,
  // interrupt
  output var  logic        irq
);

  // software-visible registers, plus the internal live compares compare_value_a_q and compare_value_b_q
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] count_value_q;
  logic [7:0] cmp_buf_a_q;
  logic [7:0] cmp_buf_b_q;
  logic [7:0] compare_value_a_q;
  logic [7:0] compare_value_b_q;
  logic [7:0] stat_q;
  logic [7:0] mask_q;
  logic [7:0] dir_q;
  // internal timer state
  logic       count_up_q;
  logic       block_q;
  logic       pend_a_q;
  logic       pend_b_q;
  logic       wave_a_q;
  logic       wave_b_q;

  // bus handshake decode
  logic       wr_go;
  logic       rd_go;
  logic [7:0] wbyte;
  logic       wr_hit;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  assign wbyte = s_axi_wdata[7:0];
  assign wr_hit = wr_go && s_axi_wstrb[0];

  // mode decode
  logic [1:0] out_a_action_field;
  logic [1:0] out_b_action_field;
  logic [2:0] wave_mode;
  logic       timer_tick_enable;
  logic       is_fast;
  logic       is_pc;
  logic       is_ctc;
  logic       is_norm;
  logic       top_from_a;
  logic [7:0] top_val;
  logic       at_top;
  logic       at_bottom;
  logic       mode_ok;
  logic       a_pwm_off;
  assign out_a_action_field = ctrl_a_q[TWC_A_FLD_HI:TWC_A_FLD_LO];
  assign out_b_action_field = ctrl_a_q[TWC_B_FLD_HI:TWC_B_FLD_LO];
  assign wave_mode = {ctrl_b_q[TWC_B_MODE_HI], ctrl_a_q[1:0]};
  // tick is a plain enable on mclk, never a clock of its own
  assign timer_tick_enable = mclk_en && ctrl_b_q[TWC_B_RUN];
  assign is_norm = wave_mode == TWC_M_NORMAL;
  assign is_ctc = wave_mode == TWC_M_CTC;
  assign is_fast = (wave_mode == TWC_M_FP_MAX) || (wave_mode == TWC_M_FP_OCA);
  assign is_pc = (wave_mode == TWC_M_PC_MAX) || (wave_mode == TWC_M_PC_OCA);
  assign top_from_a = is_ctc || (wave_mode == TWC_M_FP_OCA) || (wave_mode == TWC_M_PC_OCA);
  assign top_val = top_from_a ? compare_value_a_q : TWC_MAX;
  assign at_top = count_value_q == top_val;
  assign at_bottom = count_value_q == TWC_BOTTOM;
  // reserved modes 4 and 6 hold still and raise nothing
  assign mode_ok = is_norm || is_ctc || is_fast || is_pc;
  // pwm toggle without the high mode bit leaves the pin to the port
  assign a_pwm_off = (is_fast || is_pc) && out_a_action_field == TWC_ACT_TGL && !ctrl_b_q[TWC_B_MODE_HI];

  // compare matches, suppressed on the tick after a counter write and in reserved modes
  logic match_a;
  logic match_b;
  logic a_top_flag;
  assign match_a = (count_value_q == compare_value_a_q) && !block_q && mode_ok;
  assign match_b = (count_value_q == compare_value_b_q) && !block_q && mode_ok;
  assign a_top_flag = top_from_a && (is_ctc || is_fast);

  // next output level for one channel
  function automatic logic wave_next(
    input logic       cur,
    input logic [1:0] fld,
    input logic       match,
    input logic       cmp_is_top,
    input logic       tgl_ok
  );
    logic lvl;
    lvl = cur;
    if (is_fast) begin
      // with clear or set the bottom action wins, so a match at top is ignored
      if (match && !(cmp_is_top && fld[1])) begin
        if (fld == TWC_ACT_TGL && tgl_ok) begin
          lvl = !cur;
        end else if (fld == TWC_ACT_CLR) begin
          lvl = 1'b0;
        end else if (fld == TWC_ACT_SET) begin
          lvl = 1'b1;
        end
      end
      if (at_top && fld == TWC_ACT_CLR) begin
        lvl = 1'b1;
      end else if (at_top && fld == TWC_ACT_SET) begin
        lvl = 1'b0;
      end
    end else if (is_pc) begin
      if (cmp_is_top && fld[1]) begin
        // match dropped; level forced when the counter sits at top
        if (at_top) begin
          lvl = (fld == TWC_ACT_CLR);
        end
      end else if (match) begin
        if (fld == TWC_ACT_TGL && tgl_ok) begin
          lvl = !cur;
        end else if (fld == TWC_ACT_CLR) begin
          lvl = !count_up_q;
        end else if (fld == TWC_ACT_SET) begin
          lvl = count_up_q;
        end
      end
    end else if (match) begin
      case (fld)
        TWC_ACT_TGL: lvl = !cur;
        TWC_ACT_CLR: lvl = 1'b0;
        TWC_ACT_SET: lvl = 1'b1;
        default:     lvl = cur;
      endcase
    end
    return lvl;
  endfunction

  // event strobes for the status register
  logic ovf_set;
  logic ma_set;
  logic mb_set;
  always_comb begin
    ovf_set = 1'b0;
    if (timer_tick_enable) begin
      if (is_norm || is_ctc || wave_mode == TWC_M_FP_MAX) begin
        ovf_set = count_value_q == TWC_MAX;
      end else if (is_pc) begin
        ovf_set = at_bottom && !count_up_q;
      end else if (wave_mode == TWC_M_FP_OCA) begin
        ovf_set = at_top;
      end
    end
  end
  // a-at-top flags with the clearing tick; others one tick late
  assign ma_set = timer_tick_enable && (a_top_flag ? (at_top && !block_q) : pend_a_q);
  assign mb_set = timer_tick_enable && pend_b_q;

  // match pending, carried to the following tick
  always_ff @(posedge mclk) begin
    if (srst) begin
      pend_a_q <= 1'b0;
      pend_b_q <= 1'b0;
    end else if (timer_tick_enable) begin
      pend_a_q <= match_a && !a_top_flag;
      pend_b_q <= match_b;
    end
  end

  // counter sequence and direction
  always_ff @(posedge mclk) begin
    if (srst) begin
      count_value_q <= TWC_BOTTOM;
      count_up_q <= 1'b1;
      block_q <= 1'b0;
    end else if (mclk_en) begin
      if (wr_hit && s_axi_awaddr == TWC_OFS_COUNT) begin
        // software write wins over the tick and masks the next match
        count_value_q <= wbyte;
        block_q <= 1'b1;
      end else if (timer_tick_enable) begin
        block_q <= 1'b0;
        if (is_pc) begin
          if (count_up_q && at_top) begin
            count_up_q <= 1'b0;
            count_value_q <= at_bottom ? TWC_BOTTOM : count_value_q - TWC_ONE;
          end else if (!count_up_q && at_bottom) begin
            count_up_q <= 1'b1;
            count_value_q <= at_top ? TWC_BOTTOM : TWC_ONE;
          end else begin
            count_value_q <= count_up_q ? count_value_q + TWC_ONE : count_value_q - TWC_ONE;
          end
        end else if (is_ctc || is_fast) begin
          count_up_q <= 1'b1;
          count_value_q <= at_top ? TWC_BOTTOM : count_value_q + TWC_ONE;
        end else if (is_norm) begin
          count_up_q <= 1'b1;
          count_value_q <= count_value_q + TWC_ONE;
        end
      end
    end
  end

  // compare buffers, copied at top in pwm modes
  always_ff @(posedge mclk) begin
    if (srst) begin
      compare_value_a_q <= TWC_RST_BYTE;
      compare_value_b_q <= TWC_RST_BYTE;
    end else if (mclk_en) begin
      if (!(is_fast || is_pc) || (timer_tick_enable && at_top)) begin
        compare_value_a_q <= cmp_buf_a_q;
        compare_value_b_q <= cmp_buf_b_q;
      end
    end
  end

  // waveform latches
  always_ff @(posedge mclk) begin
    if (srst) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end else if (timer_tick_enable) begin
      wave_a_q <= wave_next(wave_a_q, out_a_action_field, match_a,
                            compare_value_a_q == top_val, ctrl_b_q[TWC_B_MODE_HI]);
      wave_b_q <= wave_next(wave_b_q, out_b_action_field, match_b,
                            compare_value_b_q == top_val, 1'b0);
    end
  end

  // pin drive; oe needs both a live field and the direction bit
  always_ff @(posedge mclk) begin
    if (srst) begin
      compare_output_a <= 1'b0;
      compare_output_a_oe <= 1'b0;
      compare_output_b <= 1'b0;
      compare_output_b_oe <= 1'b0;
    end else if (mclk_en) begin
      compare_output_a <= wave_a_q;
      compare_output_a_oe <= (|out_a_action_field) && !a_pwm_off && dir_q[TWC_DIR_A];
      compare_output_b <= wave_b_q;
      compare_output_b_oe <= (|out_b_action_field) && dir_q[TWC_DIR_B];
    end
  end

  // configuration registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_a_q <= TWC_RST_BYTE;
      ctrl_b_q <= TWC_RST_BYTE;
      cmp_buf_a_q <= TWC_RST_BYTE;
      cmp_buf_b_q <= TWC_RST_BYTE;
      mask_q <= TWC_RST_BYTE;
      dir_q <= TWC_RST_BYTE;
    end else if (mclk_en && wr_hit) begin
      case (s_axi_awaddr)
        TWC_OFS_CTRL_A: ctrl_a_q <= wbyte & TWC_CTRL_A_WMASK;
        TWC_OFS_CTRL_B: ctrl_b_q <= wbyte & TWC_CTRL_B_WMASK;
        TWC_OFS_CMP_A:  cmp_buf_a_q <= wbyte;
        TWC_OFS_CMP_B:  cmp_buf_b_q <= wbyte;
        TWC_OFS_MASK:   mask_q <= wbyte & TWC_ST_WMASK;
        TWC_OFS_DIR:    dir_q <= wbyte & TWC_DIR_WMASK;
        default:        ;
      endcase
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  logic [7:0] stat_set;
  logic [7:0] stat_clr;
  always_comb begin
    stat_set = TWC_RST_BYTE;
    stat_set[TWC_ST_OVF] = ovf_set;
    stat_set[TWC_ST_MA] = ma_set;
    stat_set[TWC_ST_MB] = mb_set;
    stat_clr = (wr_hit && s_axi_awaddr == TWC_OFS_STAT) ? (wbyte & TWC_ST_WMASK) : TWC_RST_BYTE;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      stat_q <= TWC_RST_BYTE;
      irq <= 1'b0;
    end else if (mclk_en) begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      irq <= |(stat_q & mask_q);
    end
  end

  // write channel: address and data taken together, then response
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TWC_RESP_OKAY;
    end else if (mclk_en) begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        case (s_axi_awaddr)
          TWC_OFS_CTRL_A, TWC_OFS_CTRL_B, TWC_OFS_COUNT, TWC_OFS_CMP_A,
          TWC_OFS_CMP_B, TWC_OFS_STAT, TWC_OFS_MASK, TWC_OFS_DIR:
                   s_axi_bresp <= TWC_RESP_OKAY;
          default: s_axi_bresp <= TWC_RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= TWC_RST_WORD;
      s_axi_rresp <= TWC_RESP_OKAY;
    end else if (mclk_en) begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= TWC_RESP_OKAY;
        s_axi_rdata <= TWC_RST_WORD;
        case (s_axi_araddr)
          TWC_OFS_CTRL_A: s_axi_rdata[7:0] <= ctrl_a_q;
          TWC_OFS_CTRL_B: s_axi_rdata[7:0] <= ctrl_b_q;
          TWC_OFS_COUNT:  s_axi_rdata[7:0] <= count_value_q;
          TWC_OFS_CMP_A:  s_axi_rdata[7:0] <= cmp_buf_a_q;
          TWC_OFS_CMP_B:  s_axi_rdata[7:0] <= cmp_buf_b_q;
          TWC_OFS_STAT:   s_axi_rdata[7:0] <= stat_q;
          TWC_OFS_MASK:   s_axi_rdata[7:0] <= mask_q;
          TWC_OFS_DIR:    s_axi_rdata[7:0] <= dir_q;
          default:        s_axi_rresp <= TWC_RESP_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// >>> dv/twc_monitor.sv
// bus and pin assertions for the timer waveform block
`timescale 1ns/100ps
`default_nettype none
module twc_monitor (
  // clock, reset, freeze
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        mclk_en,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pins and interrupt
  input wire logic        compare_output_a,
  input wire logic        compare_output_a_oe,
  input wire logic        compare_output_b,
  input wire logic        compare_output_b_oe,
  input wire logic        irq
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_write_answer: assert property (mclk_en && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
    |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write not answered next cycle");
  a_read_answer: assert property (mclk_en && s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
    |=> s_axi_arready && s_axi_rvalid) else $error("read not answered next cycle");
  a_aw_pulse: assert property (mclk_en && s_axi_awready |=> !s_axi_awready) else $error("awready longer than one cycle");
  a_ar_pulse: assert property (mclk_en && s_axi_arready |=> !s_axi_arready) else $error("arready longer than one cycle");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  // without the enable the pin levels and irq may not move
  a_freeze_outputs: assert property (!mclk_en |=> $stable(compare_output_a) && $stable(compare_output_b) && $stable(irq))
    else $error("outputs moved while frozen");
  a_reset_quiet: assert property ($fell(srst) |-> !irq && !compare_output_a_oe && !compare_output_b_oe && !s_axi_bvalid)
    else $error("outputs active after reset");

  // main scenarios
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(irq));
endmodule
`default_nettype wire

// >>> dv/twc_top_test.sv
// self-checking bench for the timer waveform block
`timescale 1ns/100ps
`default_nettype none
module twc_top_test
  import twc_pkg::*;
;
  // one table row: mode, fields, compares, expected periods, b inverse of a
  typedef struct {logic [2:0] m; logic [1:0] fa, fb; logic [7:0] ca, cb; int pa, pb; bit inv;} twc_case_s;
  // design ports
  logic        mclk, srst, mclk_en, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        compare_output_a, compare_output_a_oe, compare_output_b, compare_output_b_oe;
  // bench state
  int          n_fail, num_checks, p, bad;
  logic [31:0] rv, x;
  logic [1:0]  rr, br;
  twc_case_s   tb [6] = '{'{3'h3, 2'h2, 2'h3, 8'h40, 8'h40, 256, 256, 1}, '{3'h1, 2'h2, 2'h3, 8'h40, 8'h40, 510, 510, 1},
                          '{3'h7, 2'h1, 2'h2, 8'h40, 8'h10, 130, 65, 0}, '{3'h5, 2'h1, 2'h2, 8'h40, 8'h10, 256, 128, 0},
                          '{3'h2, 2'h1, 2'h1, 8'h03, 8'h01, 8, 8, 0}, '{3'h0, 2'h1, 2'h1, 8'h80, 8'h80, 512, 512, 0}};

  twc_top dut (.*);

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // leading edge keeps back-to-back calls from driving twice in one step
  // no cycle limit in the bus tasks; the watchdog ends a hung wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      br = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  // cycles between 2nd and 3rd rising edge; start-up edges may be skewed
  task automatic per(input bit b, output int q);
    logic o, l;
    int e, t;
    e = 0;
    t = 0;
    q = 0;
    l = b ? compare_output_b : compare_output_a;
    while (e < 3 && t < 3000) begin
      @(posedge mclk);
      o = b ? compare_output_b : compare_output_a;
      t++;
      if (o === 1'h1 && l === 1'h0) begin
        e++;
        if (e == 2) q = t;
      end
      l = o;
    end
    q = t - q;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    tally_and_finish;
  end

  initial begin
    {srst, mclk_en, s_axi_wstrb} = 6'h31;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {n_fail, num_checks} = 64'h0;
    repeat (16) @(posedge mclk);
    srst <= 1'h0;
    // reset words, then one unmapped place
    for (int i = 0; i < 9; i++) begin
      rd(8'(i * 4));
      chk("reset word", TWC_RST_WORD, rv);
      chk("read resp", i < 8 ? TWC_RESP_OKAY : TWC_RESP_SLVERR, rr);
    end
    wr(8'h20, 32'hff);
    chk("bad write resp", TWC_RESP_SLVERR, br);
    wr(TWC_OFS_CTRL_A, 32'hff);
    rd(TWC_OFS_CTRL_A);
    chk("ctrl a", 32'hf3, rv);
    // overflow raised masked, then unmasked, then cleared
    wr(TWC_OFS_DIR, 32'h3);
    wr(TWC_OFS_CTRL_A, 32'h0);
    wr(TWC_OFS_COUNT, 32'hfc);
    wr(TWC_OFS_CTRL_B, 32'h1);
    repeat (20) @(posedge mclk);
    chk("irq masked", 0, irq);
    chk("oe field off", 0, {compare_output_b_oe, compare_output_a_oe});
    rd(TWC_OFS_STAT);
    chk("overflow flag", 1, rv[TWC_ST_OVF]);
    wr(TWC_OFS_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq", 1, irq);
    wr(TWC_OFS_STAT, 32'h7);
    repeat (2) @(posedge mclk);
    chk("irq cleared", 0, irq);
    mclk_en <= 1'h0;
    repeat (8) @(posedge mclk);
    mclk_en <= 1'h1;
    // without run the count stands
    wr(TWC_OFS_CTRL_B, 32'h0);
    rd(TWC_OFS_COUNT);
    x = rv;
    repeat (5) @(posedge mclk);
    rd(TWC_OFS_COUNT);
    chk("count held", x, rv);
    // every documented mode, set up while stopped in normal mode
    foreach (tb[i]) begin
      wr(TWC_OFS_CTRL_B, 32'h0);
      wr(TWC_OFS_STAT, 32'h7);
      wr(TWC_OFS_CTRL_A, 32'h0);
      wr(TWC_OFS_CMP_A, {24'h0, tb[i].ca});
      wr(TWC_OFS_CMP_B, {24'h0, tb[i].cb});
      wr(TWC_OFS_COUNT, 32'h0);
      wr(TWC_OFS_CTRL_A, {24'h0, tb[i].fa, tb[i].fb, 2'h0, tb[i].m[1:0]});
      wr(TWC_OFS_CTRL_B, {28'h0, tb[i].m[2], 3'h1});
      per(1'b0, p);
      chk("period a", tb[i].pa, p);
      per(1'b1, p);
      chk("period b", tb[i].pb, p);
      chk("oe on", 3, {compare_output_b_oe, compare_output_a_oe});
      bad = 0;
      repeat (520) begin
        @(posedge mclk);
        if (tb[i].inv && compare_output_b !== ~compare_output_a) bad++;
      end
      chk("b inverse of a", 0, bad);
      // both matches seen; overflow unless the short clear-on-match top hides max
      rd(TWC_OFS_STAT);
      chk("status flags", {29'h0, 2'h3, tb[i].m != TWC_M_CTC}, rv);
    end
    // compare at top with upper bit set: match dropped, level pinned high
    for (int k = 0; k < 2; k++) begin
      wr(TWC_OFS_CTRL_B, 32'h0);
      wr(TWC_OFS_CTRL_A, 32'h0);
      wr(TWC_OFS_CMP_A, 32'hff);
      wr(TWC_OFS_CTRL_A, {24'h0, TWC_ACT_CLR, TWC_ACT_OFF, 2'h0, k ? 2'h1 : 2'h3});
      wr(TWC_OFS_CTRL_B, 32'h1);
      repeat (520) @(posedge mclk);
      bad = 0;
      repeat (520) begin
        @(posedge mclk);
        if (compare_output_a !== 1'h1) bad++;
      end
      chk("level at top", 0, bad);
    end
    // fast pwm toggle without the high mode bit gives the pin back
    wr(TWC_OFS_CTRL_B, 32'h0);
    wr(TWC_OFS_CTRL_A, 32'h43);
    repeat (2) @(posedge mclk);
    chk("oe toggle off", 0, compare_output_a_oe);
    // reserved mode 4: counter stands, no flags
    wr(TWC_OFS_STAT, 32'h7);
    wr(TWC_OFS_CTRL_A, 32'h50);
    wr(TWC_OFS_CTRL_B, 32'h9);
    rd(TWC_OFS_COUNT);
    x = rv;
    repeat (5) @(posedge mclk);
    rd(TWC_OFS_COUNT);
    chk("reserved count", x, rv);
    rd(TWC_OFS_STAT);
    chk("reserved flags", 0, rv);
    wr(TWC_OFS_DIR, 32'h0);
    repeat (3) @(posedge mclk);
    chk("oe direction", 0, {compare_output_b_oe, compare_output_a_oe});
    tally_and_finish;
  end
endmodule

bind twc_top twc_monitor u_mon (.*);
`default_nettype wire
